// ===== verilog/fpa_pkg.sv
package fpa_pkg;

  // register byte offsets on the apb window
  localparam int          FPA_ADDR_W          = 12;
  localparam logic [11:0] FPA_OFF_RO0_START   = 12'h024;
  localparam logic [11:0] FPA_OFF_RO0_END     = 12'h028;
  localparam logic [11:0] FPA_OFF_WP0         = 12'h02c;
  localparam logic [11:0] FPA_OFF_WP1         = 12'h030;
  localparam logic [11:0] FPA_OFF_RO1_START   = 12'h034;
  localparam logic [11:0] FPA_OFF_RO1_END     = 12'h038;
  localparam logic [11:0] FPA_OFF_SECURE      = 12'h080;
  localparam logic [11:0] FPA_OFF_PROD_IDENT  = 12'h110;

  // field layouts
  localparam int FPA_SUB_LSB        = 0;
  localparam int FPA_SUB_W          = 7;
  localparam int FPA_WP_FIRST_LSB   = 0;
  localparam int FPA_WP_LAST_LSB    = 16;
  localparam int FPA_WP_W           = 6;
  localparam int FPA_ERASE_BIT      = 31;
  localparam int FPA_BOOT_LOCK_BIT  = 16;
  localparam int FPA_PAGE_CNT_LSB   = 0;
  localparam int FPA_PAGE_CNT_W     = 7;

  // reset values of the held fields
  localparam logic [6:0]  FPA_SUB_RST       = 7'h00;
  localparam logic [5:0]  FPA_WP_RST        = 6'h00;
  localparam logic [0:0]  FPA_BIT_RST       = 1'h0;
  localparam logic [6:0]  FPA_PAGE_CNT_RST  = 7'h00;
  localparam logic [31:0] FPA_IDENT_RST     = 32'h0000_0000;

  // apb answers
  localparam logic [3:0]  FPA_STRB_WORD     = 4'hf;
  localparam logic [31:0] FPA_WORD_ZERO     = 32'h0000_0000;

  // security level byte encodings
  localparam logic [7:0]  FPA_LVL_NONE_BYTE = 8'ha5;
  localparam logic [7:0]  FPA_LVL_HIGH_BYTE = 8'hcc;

  // secure user area base address
  localparam logic [31:0] FPA_SECURE_BASE   = 32'h0800_0000;

  typedef enum logic [1:0] {
    FPA_LVL_NONE,
    FPA_LVL_LOW,
    FPA_LVL_HIGH
  } fpa_level_t;

endpackage

// ===== verilog/fpa_field_reg.sv
`timescale 1ns/100ps

// one software-written field with its own write enable and reset value
module fpa_field_reg
  import fpa_pkg::*;
#(
  parameter int           W   = 7,
  parameter logic [W-1:0] RST = '0
)
(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] field_q
);

  logic [W-1:0] field_reg;

  // store the field on an accepted write
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      field_reg <= RST;
    else if (wr_en)
      field_reg <= wr_data;
  end

  assign field_q = field_reg;

endmodule

// ===== verilog/fpa_level_decode.sv
`timescale 1ns/100ps

// turns the security level byte into a level and flags a drop from low to none
module fpa_level_decode
  import fpa_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [7:0] level_byte,
  output fpa_level_t      level,
  output logic            drop_pulse
);

  fpa_level_t level_reg;
  fpa_level_t level_next;
  logic       loaded_reg;
  logic       drop_reg;

  // only 0xa5 is open and only 0xcc is high; all else is low
  assign level_next = (level_byte == FPA_LVL_NONE_BYTE) ? FPA_LVL_NONE :
                      (level_byte == FPA_LVL_HIGH_BYTE) ? FPA_LVL_HIGH :
                      FPA_LVL_LOW;

  // level starts at low so nothing is exposed before the first sample
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      level_reg  <= FPA_LVL_LOW;
      loaded_reg <= 1'b0;
      drop_reg   <= 1'b0;
    end
    else
    begin
      level_reg  <= level_next;
      loaded_reg <= 1'b1;
      drop_reg   <= loaded_reg && (level_reg == FPA_LVL_LOW) && (level_next == FPA_LVL_NONE);
    end
  end

  assign level      = level_reg;
  assign drop_pulse = drop_reg;

endmodule

// ===== verilog/fpa_protect_regs.sv
`timescale 1ns/100ps

module fpa_protect_regs
  import fpa_pkg::*;
#(
  parameter int PAGE_SHIFT = 10
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic [FPA_ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [7:0]            security_level_byte,
  input  wire logic [31:0]           product_ident_otp,
  output logic      [6:0]            ro_region0_first_subpage,
  output logic      [6:0]            ro_region0_last_subpage,
  output logic      [6:0]            ro_region1_first_subpage,
  output logic      [6:0]            ro_region1_last_subpage,
  output logic                       erase_on_level_drop,
  output logic                       ro_erase_req,
  output logic      [5:0]            wp_region0_first_page,
  output logic      [5:0]            wp_region0_last_page,
  output logic      [5:0]            wp_region1_first_page,
  output logic      [5:0]            wp_region1_last_page,
  output logic                       boot_lock,
  output logic                       boot_main_flash_only,
  output logic      [6:0]            secure_area_page_count,
  output logic      [31:0]           secure_area_base,
  output logic      [31:0]           secure_area_size,
  output logic                       level_unprotected,
  output logic                       level_high,
  output logic      [31:0]           product_ident
);

  // apb handshake state
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;

  // derived outputs
  logic        erase_req_reg;
  logic        boot_only_reg;
  logic [31:0] secure_base_reg;
  logic [31:0] secure_size_reg;
  logic [31:0] secure_size_next;
  logic        level_open_reg;
  logic        level_high_reg;
  logic [31:0] ident_reg;
  logic        ident_taken_reg;

  // field values from the storage cells
  logic [6:0]  ro0_first_q;
  logic [6:0]  ro0_last_q;
  logic [6:0]  ro1_first_q;
  logic [6:0]  ro1_last_q;
  logic [0:0]  erase_en_q;
  logic [5:0]  wp0_first_q;
  logic [5:0]  wp0_last_q;
  logic [5:0]  wp1_first_q;
  logic [5:0]  wp1_last_q;
  logic [0:0]  boot_lock_q;
  logic [6:0]  page_cnt_q;

  // level decode results
  fpa_level_t  level_now;
  logic        level_drop;

  // access phase detection; the answer comes one cycle into the access phase
  wire access_phase = psel && penable && !pready_reg;
  wire word_access  = !pwrite || (pstrb == FPA_STRB_WORD);

  // address decode
  wire hit_ro0_start = (paddr == FPA_OFF_RO0_START);
  wire hit_ro0_end   = (paddr == FPA_OFF_RO0_END);
  wire hit_wp0       = (paddr == FPA_OFF_WP0);
  wire hit_wp1       = (paddr == FPA_OFF_WP1);
  wire hit_ro1_start = (paddr == FPA_OFF_RO1_START);
  wire hit_ro1_end   = (paddr == FPA_OFF_RO1_END);
  wire hit_secure    = (paddr == FPA_OFF_SECURE);
  wire hit_ident     = (paddr == FPA_OFF_PROD_IDENT);
  wire hit_any       = hit_ro0_start || hit_ro0_end || hit_wp0 || hit_wp1 ||
                       hit_ro1_start || hit_ro1_end || hit_secure || hit_ident;

  // error on unmapped address, partial write or write to the identifier
  wire bad_access    = !hit_any || !word_access || (pwrite && hit_ident);

  // a write is taken only when it is good and the access phase answers
  wire wr_ok         = access_phase && pwrite && !bad_access;

  // per register write strobes
  wire wr_ro0_start  = wr_ok && hit_ro0_start;
  wire wr_ro0_end    = wr_ok && hit_ro0_end;
  wire wr_wp0        = wr_ok && hit_wp0;
  wire wr_wp1        = wr_ok && hit_wp1;
  wire wr_ro1_start  = wr_ok && hit_ro1_start;
  wire wr_ro1_end    = wr_ok && hit_ro1_end;
  wire wr_secure     = wr_ok && hit_secure;

  // page count is locked unless the level is open; boot lock is not
  wire wr_page_cnt   = wr_secure && (level_now == FPA_LVL_NONE);

  // readout region zero start
  fpa_field_reg #(.W(FPA_SUB_W), .RST(FPA_SUB_RST)) u_ro0_first
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_ro0_start),
    .wr_data (pwdata[FPA_SUB_LSB +: FPA_SUB_W]),
    .field_q (ro0_first_q)
  );

  // readout region zero end
  fpa_field_reg #(.W(FPA_SUB_W), .RST(FPA_SUB_RST)) u_ro0_last
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_ro0_end),
    .wr_data (pwdata[FPA_SUB_LSB +: FPA_SUB_W]),
    .field_q (ro0_last_q)
  );

  // erase enable shares the region zero end register
  fpa_field_reg #(.W(1), .RST(FPA_BIT_RST)) u_erase_en
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_ro0_end),
    .wr_data (pwdata[FPA_ERASE_BIT +: 1]),
    .field_q (erase_en_q)
  );

  // readout region one start
  fpa_field_reg #(.W(FPA_SUB_W), .RST(FPA_SUB_RST)) u_ro1_first
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_ro1_start),
    .wr_data (pwdata[FPA_SUB_LSB +: FPA_SUB_W]),
    .field_q (ro1_first_q)
  );

  // readout region one end
  fpa_field_reg #(.W(FPA_SUB_W), .RST(FPA_SUB_RST)) u_ro1_last
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_ro1_end),
    .wr_data (pwdata[FPA_SUB_LSB +: FPA_SUB_W]),
    .field_q (ro1_last_q)
  );

  // write region zero, last page in the upper half
  fpa_field_reg #(.W(FPA_WP_W), .RST(FPA_WP_RST)) u_wp0_last
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_wp0),
    .wr_data (pwdata[FPA_WP_LAST_LSB +: FPA_WP_W]),
    .field_q (wp0_last_q)
  );

  // write region zero, first page in the lower half
  fpa_field_reg #(.W(FPA_WP_W), .RST(FPA_WP_RST)) u_wp0_first
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_wp0),
    .wr_data (pwdata[FPA_WP_FIRST_LSB +: FPA_WP_W]),
    .field_q (wp0_first_q)
  );

  // write region one, last page
  fpa_field_reg #(.W(FPA_WP_W), .RST(FPA_WP_RST)) u_wp1_last
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_wp1),
    .wr_data (pwdata[FPA_WP_LAST_LSB +: FPA_WP_W]),
    .field_q (wp1_last_q)
  );

  // write region one, first page
  fpa_field_reg #(.W(FPA_WP_W), .RST(FPA_WP_RST)) u_wp1_first
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_wp1),
    .wr_data (pwdata[FPA_WP_FIRST_LSB +: FPA_WP_W]),
    .field_q (wp1_first_q)
  );

  // boot lock bit of the secure area register
  fpa_field_reg #(.W(1), .RST(FPA_BIT_RST)) u_boot_lock
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_secure),
    .wr_data (pwdata[FPA_BOOT_LOCK_BIT +: 1]),
    .field_q (boot_lock_q)
  );

  // secure area page count, guarded by the level
  fpa_field_reg #(.W(FPA_PAGE_CNT_W), .RST(FPA_PAGE_CNT_RST)) u_page_cnt
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (wr_page_cnt),
    .wr_data (pwdata[FPA_PAGE_CNT_LSB +: FPA_PAGE_CNT_W]),
    .field_q (page_cnt_q)
  );

  // security level from the option byte
  fpa_level_decode u_level
  (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .level_byte (security_level_byte),
    .level      (level_now),
    .drop_pulse (level_drop)
  );

  // read words; reserved bits are tied to zero
  wire [31:0] rd_ro0_start = {25'h0000000, ro0_first_q};
  wire [31:0] rd_ro0_end   = {erase_en_q, 24'h000000, ro0_last_q};
  wire [31:0] rd_wp0       = {10'h000, wp0_last_q, 10'h000, wp0_first_q};
  wire [31:0] rd_wp1       = {10'h000, wp1_last_q, 10'h000, wp1_first_q};
  wire [31:0] rd_ro1_start = {25'h0000000, ro1_first_q};
  wire [31:0] rd_ro1_end   = {25'h0000000, ro1_last_q};
  wire [31:0] rd_secure    = {15'h0000, boot_lock_q, 9'h000, page_cnt_q};

  // read select
  wire [31:0] rd_word = hit_ro0_start ? rd_ro0_start :
                        hit_ro0_end   ? rd_ro0_end   :
                        hit_wp0       ? rd_wp0       :
                        hit_wp1       ? rd_wp1       :
                        hit_ro1_start ? rd_ro1_start :
                        hit_ro1_end   ? rd_ro1_end   :
                        hit_secure    ? rd_secure    :
                        hit_ident     ? ident_reg    :
                        FPA_WORD_ZERO;

  // apb answer: one cycle pulse on pready with data and error beside it
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= FPA_WORD_ZERO;
    end
    else
    begin
      pready_reg  <= access_phase;
      pslverr_reg <= access_phase && bad_access;
      prdata_reg  <= (access_phase && !pwrite && hit_any) ? rd_word : FPA_WORD_ZERO;
    end
  end

  // erase request follows a low to none drop while enabled
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      erase_req_reg <= 1'b0;
    else
      erase_req_reg <= level_drop && erase_en_q[0];
  end

  // boot restriction and level flags for the boot and read paths
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      boot_only_reg  <= 1'b0;
      level_open_reg <= 1'b0;
      level_high_reg <= 1'b0;
    end
    else
    begin
      boot_only_reg  <= boot_lock_q[0];
      level_open_reg <= (level_now == FPA_LVL_NONE);
      level_high_reg <= (level_now == FPA_LVL_HIGH);
    end
  end

  // secure area extent from the page count
  assign secure_size_next = 32'(page_cnt_q) << PAGE_SHIFT;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      secure_base_reg <= FPA_WORD_ZERO;
      secure_size_reg <= FPA_WORD_ZERO;
    end
    else
    begin
      secure_base_reg <= FPA_SECURE_BASE;
      secure_size_reg <= secure_size_next;
    end
  end

  // product identifier caught once after reset release, then frozen
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ident_reg       <= FPA_IDENT_RST;
      ident_taken_reg <= 1'b0;
    end
    else if (!ident_taken_reg)
    begin
      ident_reg       <= product_ident_otp;
      ident_taken_reg <= 1'b1;
    end
  end

  // outputs
  assign prdata                   = prdata_reg;
  assign pready                   = pready_reg;
  assign pslverr                  = pslverr_reg;
  assign ro_region0_first_subpage = ro0_first_q;
  assign ro_region0_last_subpage  = ro0_last_q;
  assign ro_region1_first_subpage = ro1_first_q;
  assign ro_region1_last_subpage  = ro1_last_q;
  assign erase_on_level_drop      = erase_en_q[0];
  assign ro_erase_req             = erase_req_reg;
  assign wp_region0_first_page    = wp0_first_q;
  assign wp_region0_last_page     = wp0_last_q;
  assign wp_region1_first_page    = wp1_first_q;
  assign wp_region1_last_page     = wp1_last_q;
  assign boot_lock                = boot_lock_q[0];
  assign boot_main_flash_only     = boot_only_reg;
  assign secure_area_page_count   = page_cnt_q;
  assign secure_area_base         = secure_base_reg;
  assign secure_area_size         = secure_size_reg;
  assign level_unprotected        = level_open_reg;
  assign level_high               = level_high_reg;
  assign product_ident            = ident_reg;

endmodule

// ===== testbench/fpa_protect_regs_properties.sv
`timescale 1ns/100ps

// protocol and field checks seen from the top ports only
module fpa_protect_regs_checker
  import fpa_pkg::*;
#(
  parameter int PAGE_SHIFT = 10
)
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [6:0]  ro_region0_first_subpage,
  input wire logic        erase_on_level_drop,
  input wire logic        ro_erase_req,
  input wire logic [5:0]  wp_region0_first_page,
  input wire logic [5:0]  wp_region0_last_page,
  input wire logic [6:0]  secure_area_page_count,
  input wire logic [31:0] secure_area_base,
  input wire logic [31:0] secure_area_size,
  input wire logic        level_unprotected,
  input wire logic        level_high,
  input wire logic [31:0] product_ident
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // first access-phase edge and a full-word write taken there
  wire logic take_w = psel && penable && !pready;
  wire logic wr_ok_w = take_w && pwrite && (pstrb == FPA_STRB_WORD);

  a_one_wait: assert property (take_w |=> pready ##1 !pready)
    else $error("pready not a single pulse after one wait");
  a_part_err: assert property (take_w && pwrite && pstrb != FPA_STRB_WORD |=> pslverr)
    else $error("sub-word write not refused");
  a_ident_ro: assert property (take_w && pwrite && paddr == FPA_OFF_PROD_IDENT |=> pslverr)
    else $error("identifier write not refused");
  a_ro0_store: assert property (wr_ok_w && paddr == FPA_OFF_RO0_START
    |=> ro_region0_first_subpage == 7'($past(pwdata))) else $error("first subpage not stored");
  a_wp0_store: assert property (wr_ok_w && paddr == FPA_OFF_WP0 |=>
    wp_region0_last_page == 6'($past(pwdata) >> 16) && wp_region0_first_page == 6'($past(pwdata)))
    else $error("write region pages not stored");
  a_size_calc: assert property (1'b1 |=>
    secure_area_size == ({25'h0, $past(secure_area_page_count)} << PAGE_SHIFT))
    else $error("secure size wrong");
  a_base_fixed: assert property (!$past(reset) |-> secure_area_base == FPA_SECURE_BASE)
    else $error("secure base wrong");
  a_count_lock: assert property (!$stable(secure_area_page_count) |-> $past(level_unprotected))
    else $error("page count changed while protected");
  a_erase_cause: assert property (ro_erase_req |->
    erase_on_level_drop && level_unprotected ##1 !ro_erase_req) else $error("bad erase request");
  a_ident_fixed: assert property (!$past(reset, 2) |-> $stable(product_ident))
    else $error("identifier changed");
  a_level_excl: assert property (level_high |-> !level_unprotected)
    else $error("two levels at once");

  // main scenarios reached
  c_erase: cover property (ro_erase_req);
  c_write: cover property (wr_ok_w);
  c_error: cover property (pslverr);
endmodule

bind fpa_protect_regs fpa_protect_regs_checker #(.PAGE_SHIFT(PAGE_SHIFT)) u_chk (.sys_clk, .reset,
  .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .pready, .pslverr, .ro_region0_first_subpage,
  .erase_on_level_drop, .ro_erase_req, .wp_region0_first_page, .wp_region0_last_page,
  .secure_area_page_count, .secure_area_base, .secure_area_size, .level_unprotected,
  .level_high, .product_ident);

// ===== testbench/fpa_protect_regs_tb.sv
`timescale 1ns/100ps

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module fpa_protect_regs_tb
  import fpa_pkg::*;
;
  localparam int          PS    = 4;
  localparam logic [31:0] IDENT = 32'h5a3c_0f12; // arbitrary value
  localparam logic [31:0] PAT   = 32'h8012_0a35;
  localparam logic [11:0] OFFS [7] = '{FPA_OFF_RO0_START, FPA_OFF_RO0_END, FPA_OFF_WP0,
    FPA_OFF_WP1, FPA_OFF_RO1_START, FPA_OFF_RO1_END, FPA_OFF_SECURE};
  localparam logic [31:0] MASKS [7] = '{32'h7f, 32'h8000_007f, 32'h003f_003f, 32'h003f_003f,
    32'h7f, 32'h7f, 32'h0001_007f};
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [31:0] pwdata = 32'h0, product_ident_otp = IDENT, rd;
  logic [3:0]  pstrb = 4'hf;
  logic [7:0]  security_level_byte = 8'h00;
  logic [31:0] prdata, secure_area_base, secure_area_size, product_ident;
  logic        pready, pslverr, erase_on_level_drop, ro_erase_req, boot_lock;
  logic        boot_main_flash_only, level_unprotected, level_high;
  logic [6:0]  ro_region0_first_subpage, ro_region0_last_subpage, ro_region1_first_subpage;
  logic [6:0]  ro_region1_last_subpage, secure_area_page_count;
  logic [5:0]  wp_region0_first_page, wp_region0_last_page, wp_region1_first_page;
  logic [5:0]  wp_region1_last_page;
  int          n_mismatch = 0, checked = 0, cyc = 0, p;

  fpa_protect_regs #(.PAGE_SHIFT(PS)) dut (.sys_clk, .reset, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .security_level_byte, .product_ident_otp,
    .ro_region0_first_subpage, .ro_region0_last_subpage, .ro_region1_first_subpage,
    .ro_region1_last_subpage, .erase_on_level_drop, .ro_erase_req, .wp_region0_first_page,
    .wp_region0_last_page, .wp_region1_first_page, .wp_region1_last_page, .boot_lock,
    .boot_main_flash_only, .secure_area_page_count, .secure_area_base, .secure_area_size,
    .level_unprotected, .level_high, .product_ident);

  // clock and hang guard
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // new level byte, then count erase pulses over six edges
  task automatic lvl(input logic [7:0] b);
    @(posedge sys_clk);
    security_level_byte <= b;
    p = 0;
    repeat (6)
    begin
      @(posedge sys_clk);
      if (ro_erase_req !== 1'b0) p++;
    end
  endtask

  task automatic t_reset();
    for (int i = 0; i < 7; i++)
    begin
      apb(OFFS[i], 1'b0, 32'h0, 4'hf);
      `CHK(rd, 32'h0)
    end
    apb(FPA_OFF_PROD_IDENT, 1'b0, 32'h0, 4'hf);
    `CHK(rd, IDENT)
    $display("t_reset done");
  endtask

  // all ones, then a pattern; reserved bits must read zero
  task automatic t_fields();
    lvl(FPA_LVL_NONE_BYTE);
    for (int i = 0; i < 14; i++)
    begin
      apb(OFFS[i % 7], 1'b1, (i < 7) ? 32'hffff_ffff : PAT, 4'hf);
      apb(OFFS[i % 7], 1'b0, 32'h0, 4'hf);
      `CHK(rd, ((i < 7) ? 32'hffff_ffff : PAT) & MASKS[i % 7])
    end
    `CHK({ro_region0_first_subpage, ro_region0_last_subpage}, {7'h35, 7'h35})
    `CHK({ro_region1_first_subpage, ro_region1_last_subpage}, {7'h35, 7'h35})
    `CHK({wp_region0_first_page, wp_region0_last_page}, {6'h35, 6'h12})
    `CHK({wp_region1_first_page, wp_region1_last_page}, {6'h35, 6'h12})
    `CHK({erase_on_level_drop, boot_lock}, 2'b10)
    `CHK(secure_area_size, 32'h35 << PS)
    $display("t_fields done");
  endtask

  task automatic t_err();
    apb(FPA_OFF_PROD_IDENT, 1'b1, 32'h0, 4'hf);
    `CHK(er, 1'b1)
    product_ident_otp <= 32'h0;
    apb(FPA_OFF_PROD_IDENT, 1'b0, 32'h0, 4'hf);
    `CHK(rd, IDENT)
    `CHK(product_ident, IDENT)
    apb(FPA_OFF_RO0_START, 1'b1, 32'h11, 4'h3);
    `CHK(er, 1'b1)
    apb(FPA_OFF_RO0_START, 1'b0, 32'h0, 4'hf);
    `CHK(rd, 32'h35)
    apb(12'h040, 1'b0, 32'h0, 4'hf);
    `CHK({er, rd}, {1'b1, 32'h0})
    $display("t_err done");
  endtask

  task automatic t_secure();
    apb(FPA_OFF_SECURE, 1'b1, 32'h0001_0009, 4'hf);
    @(posedge sys_clk);
    `CHK({boot_lock, boot_main_flash_only, secure_area_page_count}, {2'b11, 7'h09})
    `CHK({secure_area_base, secure_area_size}, {FPA_SECURE_BASE, 32'h9 << PS})
    lvl(FPA_LVL_HIGH_BYTE);
    `CHK({level_high, level_unprotected}, 2'b10)
    apb(FPA_OFF_SECURE, 1'b1, 32'h0000_0011, 4'hf);
    `CHK({er, boot_lock, secure_area_page_count}, {2'b00, 7'h09})
    lvl(8'h00);
    `CHK({level_high, level_unprotected}, 2'b00)
    apb(FPA_OFF_SECURE, 1'b1, 32'h0000_0022, 4'hf);
    `CHK(secure_area_page_count, 7'h09)
    $display("t_secure done");
  endtask

  // low to none erases only with the bit set; high to none never
  task automatic t_erase();
    apb(FPA_OFF_RO0_END, 1'b1, 32'h8000_0001, 4'hf);
    lvl(FPA_LVL_NONE_BYTE);
    `CHK(p, 1)
    lvl(8'h3c);
    apb(FPA_OFF_RO0_END, 1'b1, 32'h0000_0001, 4'hf);
    lvl(FPA_LVL_NONE_BYTE);
    `CHK(p, 0)
    lvl(FPA_LVL_HIGH_BYTE);
    apb(FPA_OFF_RO0_END, 1'b1, 32'h8000_0001, 4'hf);
    lvl(FPA_LVL_NONE_BYTE);
    `CHK(p, 0)
    $display("t_erase done");
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_fields();
    t_err();
    t_secure();
    t_erase();
    end_sim();
  end
endmodule
